// ---- verilog/dual_timer_pwm_defines.svh ----
// Register offsets, field codes and reset values of the dual timer block.
// Assumes a 9-bit byte address on the register bus.
`ifndef DUAL_TIMER_PWM_DEFINES_SVH
`define DUAL_TIMER_PWM_DEFINES_SVH
`define DTP_ADDR_W 9
`define DTP_GLOBAL_BIT 8
`define DTP_UNIT_BIT 7
`define DTP_CTRL_OFS 7'h00
`define DTP_COUNT_OFS 7'h04
`define DTP_MOD_OFS 7'h08
`define DTP_CH_FIRST 4'h2
`define DTP_STAT_OFS 9'h100
`define DTP_MASK_OFS 9'h104
`define DTP_IRQ_SPAN 8
`define DTP_TOF_BIT 7
`define DTP_MOD_RST 16'hffff
`define DTP_SRC_BUS 2'h0
`define DTP_SRC_FIXED 2'h1
`define DTP_SRC_EXT 2'h2
`define DTP_MODE_CAPT 2'h1
`define DTP_MODE_CMP 2'h2
`define DTP_MODE_PWM 2'h3
`define DTP_EDGE_RISE 2'h1
`define DTP_EDGE_FALL 2'h2
`define DTP_EDGE_BOTH 2'h3
`define DTP_ACT_TOGGLE 2'h1
`define DTP_ACT_CLEAR 2'h2
`define DTP_ACT_SET 2'h3
`define DTP_FIXED_DIV 2
`endif

// ---- verilog/dual_timer_pwm_pkg.sv ----
// Types shared by the dual timer block.
// Field order of each register struct matches its register bit layout.
package dual_timer_pwm_pkg;
    typedef struct packed {
        logic enable;
        logic center;
        logic [1:0] clk_sel;
        logic [2:0] prescale;
    } unit_ctrl_s;
    typedef struct packed {
        logic low_true;
        logic [1:0] edge_act;
        logic [1:0] mode;
    } chan_cfg_s;
    typedef struct packed {
        logic rise;
        logic fall;
    } edge_s;
endpackage

// ---- verilog/dual_timer_pwm.sv ----
// Two timer units with capture, compare and PWM channels, Avalon-MM slave.
// Assumes pins and clock inputs are asynchronous; GPIO drives the idle pins.
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "dual_timer_pwm_defines.svh"
module dual_timer_pwm
    import dual_timer_pwm_pkg::*;
#(
    parameter int CH_U0 = 5,
    parameter int CH_U1 = 3,
    parameter int PINS_U0 = 4,
    parameter int PINS_U1 = 1
)
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [8:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_ext_ref_clk,
    input wire logic i_bypassed_external_mode,
    input wire logic [1:0] i_ext_clk_pin,
    input wire logic [4:0] i_pin_in,
    output logic [4:0] o_pin_out,
    output logic [4:0] o_pin_oe_n,
    input wire logic [4:0] i_gpio_out,
    input wire logic [4:0] i_gpio_oe_n,
    output logic o_irq
);
    localparam int NSYNC = 8;
    localparam int NPIN = PINS_U0 + PINS_U1;
    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [15:0] wd, input logic [1:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction
    // Three-flop synchronisers; a change counts once stages two and three agree
    logic [NSYNC-1:0] sync_a_r;
    logic [NSYNC-1:0] sync_b_r;
    logic [NSYNC-1:0] sync_c_r;
    logic [NSYNC-1:0] stable_r;
    wire [NSYNC-1:0] async_in = {i_pin_in, i_ext_clk_pin, i_ext_ref_clk};
    wire [NSYNC-1:0] agree = ~(sync_b_r ^ sync_c_r);
    wire [NSYNC-1:0] rise_ev = agree & sync_c_r & ~stable_r;
    wire [NSYNC-1:0] fall_ev = agree & ~sync_c_r & stable_r;

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            sync_a_r <= '0;
            sync_b_r <= '0;
            sync_c_r <= '0;
            stable_r <= '0;
        end
        else
        begin
            sync_a_r <= async_in;
            sync_b_r <= sync_a_r;
            sync_c_r <= sync_b_r;
            stable_r <= (agree & sync_c_r) | (~agree & stable_r);
        end
    end

    // Fixed clock: every second reference rise, or every cycle when bypassed
    logic ref_half_r;
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            ref_half_r <= 1'b0;
        else if (rise_ev[0])
            ref_half_r <= ~ref_half_r;
    end
    wire fixed_tick = i_bypassed_external_mode | (rise_ev[0] & ref_half_r);

    // Avalon slave: one wait cycle, read data registered in it
    logic ack_r;
    wire req = i_avs_read | i_avs_write;
    wire wr_fire = i_avs_write & ack_r;
    wire wr_glob = wr_fire & i_avs_address[`DTP_GLOBAL_BIT];
    wire [6:0] uofs = i_avs_address[6:0];
    wire [15:0] wd_low = i_avs_writedata[15:0];
    wire [1:0] be_low = i_avs_byteenable[1:0];
    assign o_avs_waitrequest = req & ~ack_r;
    logic [15:0] stat_r;
    logic [15:0] mask_r;
    logic [15:0] irq_ev;
    logic [31:0] unit_rd [2];
    logic [4:0] pin_drv;
    logic [4:0] pin_val;
    wire sel_stat = i_avs_address == `DTP_STAT_OFS;
    wire sel_mask = i_avs_address == `DTP_MASK_OFS;
    wire [15:0] stat_clr = (wr_glob && sel_stat) ?
        (wd_low & {{8{be_low[1]}}, {8{be_low[0]}}}) : 16'h0000;
    wire [31:0] glob_rd = sel_stat ? {16'h0000, stat_r} :
        (sel_mask ? {16'h0000, mask_r} : 32'h0000_0000);
    wire [31:0] rd_mux = i_avs_address[`DTP_GLOBAL_BIT] ? glob_rd :
        unit_rd[i_avs_address[`DTP_UNIT_BIT]];
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            ack_r <= 1'b0;
            o_avs_readdata <= 32'h0000_0000;
            stat_r <= 16'h0000;
            mask_r <= 16'h0000;
        end
        else
        begin
            ack_r <= req & ~ack_r;
            o_avs_readdata <= (i_avs_read & ~ack_r) ? rd_mux : o_avs_readdata;
            // New events win over a clear in the same cycle
            stat_r <= (stat_r & ~stat_clr) | irq_ev;
            if (wr_glob && sel_mask)
                mask_r <= merge16(mask_r, wd_low, be_low);
        end
    end
    assign o_irq = |(stat_r & mask_r);
    // GPIO keeps any pin the timer is not driving
    assign o_pin_out = (pin_drv & pin_val) | (~pin_drv & i_gpio_out);
    assign o_pin_oe_n = ~pin_drv & i_gpio_oe_n;
    for (genvar u = 0; u < 2; u++)
    begin : g_unit
        localparam int NCH = (u == 0) ? CH_U0 : CH_U1;
        localparam int NP = (u == 0) ? PINS_U0 : PINS_U1;
        localparam int PBASE = (u == 0) ? 0 : PINS_U0;
        unit_ctrl_s ctrl_r;
        logic [15:0] cnt_r;
        logic [15:0] mod_r;
        logic [15:0] mod_buf_r;
        logic down_r;
        logic [6:0] presc_r;
        logic [4:0] cfg_w [8];
        logic [15:0] val_w [8];
        wire wr_unit = wr_fire & ~i_avs_address[`DTP_GLOBAL_BIT] &
            (i_avs_address[`DTP_UNIT_BIT] == 1'(u));
        wire [3:0] ch_idx = uofs[6:3] - `DTP_CH_FIRST;
        wire ch_hit = (uofs[6:3] >= `DTP_CH_FIRST) && (ch_idx < 4'(NCH));
        wire src_tick = (ctrl_r.clk_sel == `DTP_SRC_BUS) ? 1'b1 :
            (ctrl_r.clk_sel == `DTP_SRC_FIXED) ? fixed_tick :
            (ctrl_r.clk_sel == `DTP_SRC_EXT) ? rise_ev[1+u] : 1'b0;
        wire [7:0] tap = 8'h01 << ctrl_r.prescale;
        wire [6:0] tap_mask = 7'(tap - 8'h01);
        wire cnt_tick = ctrl_r.enable & src_tick &
            ((presc_r & tap_mask) == tap_mask);
        wire at_top = cnt_r >= mod_r;
        wire at_zero = cnt_r == 16'h0000;
        wire load = ~ctrl_r.enable | (cnt_tick & at_top & ~down_r);
        logic [15:0] cnt_nxt;
        logic down_nxt;
        // Up-count wraps at the modulus; center mode reverses at both ends
        always_comb
        begin
            cnt_nxt = cnt_r;
            down_nxt = down_r;
            if (!ctrl_r.center)
            begin
                cnt_nxt = at_top ? 16'h0000 : 16'(cnt_r + 16'h0001);
                down_nxt = 1'b0;
            end
            else if (down_r)
            begin
                cnt_nxt = at_zero ? 16'(cnt_r + 16'h0001) :
                    16'(cnt_r - 16'h0001);
                down_nxt = ~at_zero;
            end
            else if (at_top)
            begin
                cnt_nxt = at_zero ? cnt_r : 16'(cnt_r - 16'h0001);
                down_nxt = ~at_zero;
            end
            else
                cnt_nxt = 16'(cnt_r + 16'h0001);
        end
        wire wr_ctrl = wr_unit && uofs == `DTP_CTRL_OFS;
        wire wr_cnt = wr_unit && uofs == `DTP_COUNT_OFS;
        wire wr_mod = wr_unit && uofs == `DTP_MOD_OFS;
        always_ff @(posedge i_clock)
        begin
            if (i_sys_rst)
            begin
                ctrl_r <= '0;
                cnt_r <= 16'h0000;
                mod_r <= `DTP_MOD_RST;
                mod_buf_r <= `DTP_MOD_RST;
                down_r <= 1'b0;
                presc_r <= 7'h00;
            end
            else
            begin
                if (wr_ctrl && be_low[0])
                    ctrl_r <= unit_ctrl_s'(wd_low[6:0]);
                if (wr_mod)
                    mod_buf_r <= merge16(mod_buf_r, wd_low, be_low);
                if (load)
                    mod_r <= mod_buf_r;
                // Any write to the count restarts counter and prescaler
                if (wr_cnt)
                begin
                    cnt_r <= 16'h0000;
                    down_r <= 1'b0;
                    presc_r <= 7'h00;
                end
                else
                begin
                    if (src_tick && ctrl_r.enable)
                        presc_r <= 7'(presc_r + 7'h01);
                    if (cnt_tick)
                    begin
                        cnt_r <= cnt_nxt;
                        down_r <= down_nxt;
                    end
                end
            end
        end
        assign irq_ev[u*`DTP_IRQ_SPAN+`DTP_TOF_BIT] =
            cnt_tick & at_top & ~down_r;

        for (genvar c = 0; c < `DTP_TOF_BIT; c++)
        begin : g_ch
            if (c < NCH)
            begin : g_on
                chan_cfg_s cfg_r;
                logic [15:0] val_r;
                logic [15:0] buf_r;
                logic out_r;
                edge_s pin_e;
                wire wr_ch = wr_unit && ch_hit && ch_idx == 4'(c);
                wire wr_cfg = wr_ch && !uofs[2] && be_low[0];
                wire wr_val = wr_ch && uofs[2];
                wire is_pwm = ctrl_r.center | cfg_r.mode == `DTP_MODE_PWM;
                wire is_cmp = ~ctrl_r.center & cfg_r.mode == `DTP_MODE_CMP;
                wire is_cap = ~ctrl_r.center & cfg_r.mode == `DTP_MODE_CAPT;
                wire [1:0] ea = cfg_r.edge_act;
                wire cap_ev = is_cap &
                    ((pin_e.rise & (ea == `DTP_EDGE_RISE ||
                    ea == `DTP_EDGE_BOTH)) |
                    (pin_e.fall & (ea == `DTP_EDGE_FALL ||
                    ea == `DTP_EDGE_BOTH)));
                wire match = cnt_tick & (cnt_r == val_r);
                wire [15:0] wr_word = merge16(buf_r, wd_low, be_low);
                if (c < NP)
                begin : g_pin
                    assign pin_e = '{rise: rise_ev[3+PBASE+c],
                        fall: fall_ev[3+PBASE+c]};
                    assign pin_drv[PBASE+c] = is_pwm | is_cmp;
                    assign pin_val[PBASE+c] = out_r;
                end
                else
                begin : g_nopin
                    // Internal-only channels see no pin and never capture
                    assign pin_e = '{rise: 1'b0, fall: 1'b0};
                end
                always_ff @(posedge i_clock)
                begin
                    if (i_sys_rst)
                    begin
                        cfg_r <= '0;
                        val_r <= 16'h0000;
                        buf_r <= 16'h0000;
                        out_r <= 1'b0;
                    end
                    else
                    begin
                        if (wr_cfg)
                            cfg_r <= chan_cfg_s'(wd_low[4:0]);
                        if (wr_val)
                            buf_r <= wr_word;
                        // Capture beats a same-cycle software write
                        if (cap_ev)
                            val_r <= cnt_r;
                        else if (wr_val && !is_pwm)
                            val_r <= wr_word;
                        else if (is_pwm && load)
                            val_r <= buf_r;
                        if (is_pwm)
                            out_r <= (cnt_r < val_r) ^ cfg_r.low_true;
                        else if (is_cmp && match)
                        begin
                            if (ea == `DTP_ACT_TOGGLE)
                                out_r <= ~out_r;
                            else if (ea == `DTP_ACT_CLEAR)
                                out_r <= 1'b0;
                            else if (ea == `DTP_ACT_SET)
                                out_r <= 1'b1;
                        end
                    end
                end
                assign irq_ev[u*`DTP_IRQ_SPAN+c] =
                    cap_ev | ((is_cmp | is_pwm) & match);
                assign cfg_w[c] = cfg_r;
                assign val_w[c] = val_r;
            end
            else
            begin : g_off
                assign irq_ev[u*`DTP_IRQ_SPAN+c] = 1'b0;
                assign cfg_w[c] = 5'h00;
                assign val_w[c] = 16'h0000;
            end
        end
        assign cfg_w[`DTP_TOF_BIT] = 5'h00;
        assign val_w[`DTP_TOF_BIT] = 16'h0000;

        wire [15:0] ch_rd = uofs[2] ? val_w[ch_idx[2:0]] :
            {11'h000, cfg_w[ch_idx[2:0]]};
        assign unit_rd[u] = (uofs == `DTP_CTRL_OFS) ? {25'h0, ctrl_r} :
            (uofs == `DTP_COUNT_OFS) ? {16'h0000, cnt_r} :
            (uofs == `DTP_MOD_OFS) ? {16'h0000, mod_buf_r} :
            ch_hit ? {16'h0000, ch_rd} : 32'h0000_0000;
    end
    // Pins beyond the pinned channels stay with GPIO
    for (genvar p = NPIN; p < 5; p++)
    begin : g_spare
        assign pin_drv[p] = 1'b0;
        assign pin_val[p] = 1'b0;
    end
endmodule

// ---- verif/dual_timer_pwm_properties.sv ----
// Port-level checker for the dual timer block.
// Assumes a master that holds each request until waitrequest is low.
`timescale 1ns/10ps
module dtp_checker (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [4:0] o_pin_out,
    input wire logic [4:0] o_pin_oe_n,
    input wire logic [4:0] i_gpio_out,
    input wire logic [4:0] i_gpio_oe_n,
    input wire logic o_irq
);
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);
    sequence req_new;
        (i_avs_read || i_avs_write) && !$past(i_avs_read || i_avs_write);
    endsequence
    sequence req_wait;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    wait_first_a: assert property (req_new |-> o_avs_waitrequest)
        else $error("no wait state on new request");
    answer_one_a: assert property (req_wait |=> !o_avs_waitrequest)
        else $error("answer later than one wait state");
    idle_nowait_a: assert property (!(i_avs_read || i_avs_write)
        |-> !o_avs_waitrequest) else $error("waitrequest while idle");
    upper_zero_a: assert property (i_avs_read && !o_avs_waitrequest
        |-> o_avs_readdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    data_hold_a: assert property (!i_avs_read |=> $stable(o_avs_readdata))
        else $error("read data changed without read");
    reset_clear_a: assert property (disable iff (1'b0) i_sys_rst
        |=> !o_irq && o_avs_readdata == 32'h0000_0000
        && o_pin_oe_n == i_gpio_oe_n) else $error("bad state after reset");
    gpio_out_a: assert property (((o_pin_out ^ i_gpio_out)
        & o_pin_oe_n) == 5'h00) else $error("idle pin not from gpio");
    gpio_oe_a: assert property ((o_pin_oe_n & ~i_gpio_oe_n) == 5'h00)
        else $error("pin enable neither timer nor gpio");
    irq_drop_a: assert property ($fell(o_irq) |-> $past(i_avs_write))
        else $error("irq dropped without a write");
endmodule
bind dual_timer_pwm dtp_checker dtp_checker_inst (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_pin_out(o_pin_out),
    .o_pin_oe_n(o_pin_oe_n), .i_gpio_out(i_gpio_out),
    .i_gpio_oe_n(i_gpio_oe_n), .o_irq(o_irq));

// ---- verif/pin_partner.sv ----
// Model of the board side: shared pins, reference oscillator, clock pins.
// Assumes the bench sets the levels it drives on pins the timer leaves free.
`timescale 1ns/10ps
module pin_partner (
    input wire logic [4:0] i_pin_out,
    input wire logic [4:0] i_pin_oe_n,
    input wire logic [4:0] i_drive,
    input wire logic i_ext_run,
    output logic [4:0] o_pin_in,
    output logic o_ref_clk,
    output logic [1:0] o_ext_clk
);
    // Board ignores its own level where the timer drives the pin
    assign o_pin_in = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & i_drive);
    // Oscillator period 100.6 ns, so it drifts against i_clock
    initial o_ref_clk = 1'b0;
    always #50.3 o_ref_clk = ~o_ref_clk;
    // Clock pins stand still unless a scenario runs them
    initial o_ext_clk = 2'b00;
    always #100 o_ext_clk = i_ext_run ? ~o_ext_clk : 2'b00;
endmodule

// ---- verif/tb_dual_timer_pwm.sv ----
// Self-checking bench for the dual timer block.
// Assumes one wait state per bus access and registered pin outputs.
`timescale 1ns/10ps
module tb_dual_timer_pwm;
    import dual_timer_pwm_pkg::*;
    logic i_clock = 1'b0, i_sys_rst = 1'b1, i_avs_read = 1'b0;
    logic i_avs_write = 1'b0, i_byp = 1'b0, ext_run = 1'b0;
    logic [8:0] i_avs_address = 9'h000;
    logic [31:0] i_avs_writedata = 32'h0000_0000, o_avs_readdata, q;
    logic o_avs_waitrequest, o_irq, ref_clk;
    logic [1:0] ext_clk;
    logic [4:0] pin_in, o_pin_out, o_pin_oe_n, drive = 5'h00;
    logic [4:0] gpio_out = 5'h15;
    logic [4:0] gpio_oe_n = 5'h1f;
    int err_count = 0, comparisons = 0;
    always #12.5 i_clock = ~i_clock;
    dual_timer_pwm dual_timer_pwm_inst (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hf),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_ext_ref_clk(ref_clk),
        .i_bypassed_external_mode(i_byp), .i_ext_clk_pin(ext_clk),
        .i_pin_in(pin_in), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n),
        .i_gpio_out(gpio_out), .i_gpio_oe_n(gpio_oe_n), .o_irq(o_irq));
    pin_partner pin_partner_inst (.i_pin_out(o_pin_out),
        .i_pin_oe_n(o_pin_oe_n), .i_drive(drive), .i_ext_run(ext_run),
        .o_pin_in(pin_in), .o_ref_clk(ref_clk), .o_ext_clk(ext_clk));
    task automatic bus(input logic w, input logic [8:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= w;
        i_avs_read <= !w;
        @(posedge i_clock);
        // Waits however long the answer takes; the watchdog ends a hang
        while (o_avs_waitrequest !== 1'b0)
        begin
            @(posedge i_clock);
            n++;
        end
        q = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        chk(n, 1);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input int lo, hi);
        comparisons++;
        if ((^got === 1'bx) || got < lo || got > hi)
        begin
            err_count++;
            $display("Error at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic highs(input int b, input int n, output int h);
        h = 0;
        repeat (n)
        begin
            @(posedge i_clock);
            h += (o_pin_out[b] === 1'b1);
        end
    endtask
    task automatic meas(input logic [7:0] ctl, input int exp);
        bus(1, 9'h000, {24'h00_0000, ctl});
        bus(1, 9'h004, 32'h0000_0000);
        repeat (512) @(posedge i_clock);
        bus(0, 9'h004, 32'h0000_0000);
        chk_rng(q, exp - 2, exp + 5);
    endtask
    task automatic t_reset;
        chk(o_irq, 1'b0);
        chk(o_pin_out, gpio_out);
        bus(0, 9'h000, 0);
        chk(q, 32'h0000_0000);
        bus(0, 9'h008, 0);
        chk(q, 32'h0000_ffff);
        bus(1, 9'h0fc, 32'h0000_ffff);
        bus(0, 9'h0fc, 0);
        chk(q, 32'h0000_0000);
        bus(1, 9'h0a0, 32'h0000_0003);
        bus(0, 9'h0a0, 0);
        chk(q, 32'h0000_0003);
        bus(1, 9'h0a8, 32'h0000_0003);
        bus(0, 9'h0a8, 0);
        chk(q, 32'h0000_0000);
        gpio_oe_n <= 5'h0a;
        @(posedge i_clock);
        chk(o_pin_oe_n, 5'h0a);
        gpio_oe_n <= 5'h1f;
        $display("test reset done");
    endtask
    task automatic t_rate;
        for (int p = 0; p < 8; p++)
        begin
            meas(8'h40 | p[7:0], 512 >> p);
        end
        meas(8'h48, 64);
        i_byp <= 1'b1;
        meas(8'h48, 512);
        i_byp <= 1'b0;
        ext_run <= 1'b1;
        meas(8'h50, 64);
        ext_run <= 1'b0;
        $display("test rate done");
    endtask
    task automatic t_pwm;
        int h;
        bus(1, 9'h000, 0);
        bus(1, 9'h008, 3);
        bus(1, 9'h010, 3);
        bus(1, 9'h014, 1);
        bus(1, 9'h000, 8'h40);
        highs(0, 16, h);
        highs(0, 16, h);
        chk(h, 4);
        chk(o_pin_oe_n[0], 1'b0);
        bus(1, 9'h010, 8'h13);
        highs(0, 16, h);
        highs(0, 16, h);
        chk(h, 12);
        bus(1, 9'h010, 0);
        bus(1, 9'h000, 8'h60);
        highs(0, 18, h);
        highs(0, 18, h);
        chk(h, 3);
        chk(o_pin_oe_n[4], 1'b1);
        $display("test pwm done");
    endtask
    task automatic t_cmp;
        int h;
        bus(1, 9'h000, 8'h40);
        bus(1, 9'h01c, 1);
        bus(1, 9'h018, 8'h0e);
        highs(1, 12, h);
        chk(o_pin_out[1], 1'b1);
        bus(1, 9'h018, 8'h0a);
        highs(1, 12, h);
        chk(o_pin_out[1], 1'b0);
        bus(1, 9'h018, 8'h06);
        // Earlier scenarios left this flag set
        bus(1, 9'h100, 32'h0000_00ff);
        highs(1, 16, h);
        highs(1, 16, h);
        chk(h, 8);
        bus(0, 9'h100, 0);
        chk(q[1], 1'b1);
        $display("test compare done");
    endtask
    task automatic t_capt;
        bus(1, 9'h008, 32'h0000_ffff);
        for (int e = 1; e < 4; e++)
        begin
            bus(1, 9'h020, (e << 2) | 1);
            repeat (8) @(posedge i_clock);
            bus(1, 9'h100, 32'h0000_00ff);
            bus(1, 9'h004, 32'h0000_0000);
            drive[2] <= 1'b1;
            repeat (8) @(posedge i_clock);
            bus(0, 9'h100, 0);
            chk(q[2], e != 2);
            bus(0, 9'h024, 0);
            chk_rng(q, 2, 5);
            bus(1, 9'h100, 32'h0000_00ff);
            drive[2] <= 1'b0;
            repeat (8) @(posedge i_clock);
            bus(0, 9'h100, 0);
            chk(q[2], e != 1);
        end
        $display("test capture done");
    endtask
    task automatic t_irq;
        // Disabled unit takes the new modulus at once
        bus(1, 9'h000, 0);
        bus(1, 9'h008, 3);
        bus(1, 9'h000, 8'h40);
        repeat (20) @(posedge i_clock);
        bus(1, 9'h000, 0);
        bus(0, 9'h100, 0);
        chk(q[7], 1'b1);
        bus(1, 9'h104, 32'h0000_0080);
        @(posedge i_clock);
        chk(o_irq, 1'b1);
        bus(1, 9'h100, 32'h0000_0080);
        @(posedge i_clock);
        chk(o_irq, 1'b0);
        $display("test irq done");
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #(25 * 60000);
        err_count++;
        final_report();
    end
    initial
    begin
        repeat (4) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        t_reset();
        t_rate();
        t_pwm();
        t_cmp();
        t_capt();
        t_irq();
        final_report();
    end
endmodule
